/* File: rtl/nvram_host.sv */
// Purpose: Host controller that drives a shadowed non-volatile static RAM.
// Assumes: One request at a time on req_valid_i/req_ready_o; 25 MHz clock.
// Notes:   Data pins are three signals; the bench resolves the wire.
//
// How it works
// - Write strobe high reads, low writes.
// - Address held steady through each cycle.
// - Store needs two select-qualified low pulses.
// - Second store pulse waits 5 ms.
// - Select held 125 ns before pulse end.
// - Select leads store strobe by 25 ns.
// - Keep store strobe high at power.
`timescale 1ns/1ps
module nvram_host #(
  parameter int GAP_CYCLES   = nvram_host_pkg::CYC_GAP,
  parameter int STORE_CYCLES = nvram_host_pkg::CYC_STORE
) (
  input  wire logic                                clk_i,
  input  wire logic                                reset_n_i,
  input  wire logic                                req_valid_i,
  input  wire nvram_host_pkg::req_t                req_i,
  output logic                                     req_ready_o,
  output logic                                     rsp_valid_o,
  output logic [nvram_host_pkg::DATA_W-1:0]        rsp_data_o,
  output logic                                     busy_o,
  output nvram_host_pkg::strobes_t                 strobes_o,
  output logic [nvram_host_pkg::ADDR_W-1:0]        word_address_lines_o,
  output logic [nvram_host_pkg::DATA_W-1:0]        byte_lanes_o,
  output logic                                     byte_lanes_oe_o,
  input  wire logic [nvram_host_pkg::DATA_W-1:0]   byte_lanes_i
);

  // ----------------------------------------------------------------
  // Reset release and pin synchroniser
  // ----------------------------------------------------------------
  logic rst_a;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  logic [nvram_host_pkg::DATA_W-1:0] lanes_sync;

  nvram_pin_sync #(
    .W (nvram_host_pkg::DATA_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     (byte_lanes_i),
    .q_o     (lanes_sync)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE,
    S_SETUP,
    S_PULSE,
    S_HOLD,
    S_SAMPLE,
    S_ST_SETUP,
    S_ST_PULSE,
    S_ST_GAP,
    S_ST_WAIT,
    S_RC_PULSE,
    S_RC_WAIT
  } state_t;

  state_t                            state;
  state_t                            next_state;
  logic [31:0]                       cnt;
  logic [31:0]                       next_cnt;
  logic                              second;
  logic                              next_second;
  nvram_host_pkg::req_t              cur;
  nvram_host_pkg::strobes_t          next_strobes;
  logic                              next_oe;
  logic                              next_ready;
  logic                              next_rsp_valid;
  logic                              next_busy;

  wire is_write = (cur.op == nvram_host_pkg::OP_WRITE);
  wire done     = (cnt == 32'h0000_0000);
  wire take     = (state == S_IDLE) && req_valid_i && req_ready_o;
  wire [31:0] cnt_dec = cnt - 32'h0000_0001;

  function automatic logic [31:0] cyc(input int n);
    cyc = 32'(n - 1);
  endfunction : cyc

  always_comb begin
    next_state     = state;
    next_cnt       = done ? cnt : cnt_dec;
    next_second    = second;
    next_strobes   = '{1'b1, 1'b1, 1'b1, 1'b1};
    next_oe        = 1'b0;
    next_ready     = 1'b0;
    next_rsp_valid = 1'b0;
    next_busy      = 1'b1;
    case (state)
      S_IDLE: begin
        next_busy  = 1'b0;
        next_ready = 1'b1;
        if (take) begin
          next_ready = 1'b0;
          next_busy  = 1'b1;
          next_strobes.device_select_n = 1'b0;
          if (req_i.op == nvram_host_pkg::OP_STORE) begin
            next_state  = S_ST_SETUP;
            next_second = 1'b0;
            next_cnt    = cyc(nvram_host_pkg::CYC_SSETUP);
          end else if (req_i.op == nvram_host_pkg::OP_RECALL) begin
            next_state = S_RC_PULSE;
            next_cnt   = cyc(nvram_host_pkg::CYC_RPULSE);
            next_strobes.recall_strobe_n = 1'b0;
          end else begin
            next_state = S_SETUP;
            next_cnt   = cyc(nvram_host_pkg::CYC_SETUP);
            next_oe    = (req_i.op == nvram_host_pkg::OP_WRITE);
          end
        end
      end
      S_SETUP: begin
        next_strobes.device_select_n = 1'b0;
        next_oe = is_write;
        if (done) begin
          next_state = S_PULSE;
          next_cnt   = cyc(nvram_host_pkg::CYC_WPULSE);
          next_strobes.write_strobe_n = ~is_write;
        end
      end
      S_PULSE: begin
        next_strobes.device_select_n = 1'b0;
        next_strobes.write_strobe_n  = ~is_write;
        next_oe = is_write;
        if (done) begin
          next_state = S_HOLD;
          next_cnt   = cyc(nvram_host_pkg::CYC_CYCLE - nvram_host_pkg::CYC_SETUP - nvram_host_pkg::CYC_WPULSE);
          next_strobes.write_strobe_n = 1'b1;
        end
      end
      S_HOLD: begin
        next_strobes.device_select_n = 1'b0;
        next_oe = is_write;
        if (done) begin
          next_state = S_SAMPLE;
          next_strobes.device_select_n = 1'b1;
          next_oe = 1'b0;
        end
      end
      S_SAMPLE: begin
        // Three sync stages lag the pins, so wait out the settle count.
        next_cnt = cnt_dec;
        if (cnt[2:0] == 3'h5) begin
          next_state     = S_IDLE;
          next_rsp_valid = 1'b1;
          next_cnt       = '0;
        end
      end
      S_ST_SETUP: begin
        next_strobes.device_select_n = 1'b0;
        if (done) begin
          next_state = S_ST_PULSE;
          next_cnt   = cyc(nvram_host_pkg::CYC_SPULSE);
          next_strobes.store_strobe_n = 1'b0;
        end
      end
      S_ST_PULSE: begin
        next_strobes.device_select_n = 1'b0;
        next_strobes.store_strobe_n  = 1'b0;
        if (done) begin
          next_strobes.store_strobe_n = 1'b1;
          if (second) begin
            next_state = S_ST_WAIT;
            next_cnt   = 32'(STORE_CYCLES - 1);
            next_strobes.device_select_n = 1'b1;
          end else begin
            next_state  = S_ST_GAP;
            next_second = 1'b1;
            next_cnt    = 32'(GAP_CYCLES - 1);
          end
        end
      end
      S_ST_GAP: begin
        next_strobes.device_select_n = 1'b0;
        if (done) begin
          next_state = S_ST_PULSE;
          next_cnt   = cyc(nvram_host_pkg::CYC_SPULSE);
          next_strobes.store_strobe_n = 1'b0;
        end
      end
      S_ST_WAIT: begin
        if (done) begin
          next_state = S_IDLE;
          next_rsp_valid = 1'b1;
        end
      end
      S_RC_PULSE: begin
        next_strobes.device_select_n = 1'b0;
        next_strobes.recall_strobe_n = 1'b0;
        if (done) begin
          next_state = S_RC_WAIT;
          next_cnt   = cyc(nvram_host_pkg::CYC_RCYCLE - nvram_host_pkg::CYC_RPULSE);
          next_strobes.recall_strobe_n = 1'b1;
        end
      end
      S_RC_WAIT: begin
        if (done) begin
          next_state = S_IDLE;
          next_rsp_valid = 1'b1;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state       <= S_IDLE;
      cnt         <= '0;
      second      <= 1'b0;
      cur         <= '0;
      strobes_o   <= '{1'b1, 1'b1, 1'b1, 1'b1};
      byte_lanes_oe_o <= 1'b0;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      busy_o      <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      second      <= next_second;
      cur         <= take ? req_i : cur;
      strobes_o   <= next_strobes;
      byte_lanes_oe_o <= next_oe;
      req_ready_o <= next_ready;
      rsp_valid_o <= next_rsp_valid;
      busy_o      <= next_busy;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      word_address_lines_o <= '0;
      byte_lanes_o         <= '0;
      rsp_data_o           <= '0;
    end else begin
      word_address_lines_o <= take ? req_i.addr : word_address_lines_o;
      byte_lanes_o         <= take ? req_i.data : byte_lanes_o;
      rsp_data_o           <= (state == S_SAMPLE && !is_write) ? lanes_sync : rsp_data_o;
    end
  end

endmodule : nvram_host

/* File: rtl/nvram_host_pkg.sv */
// Purpose: Shared constants and types for the shadowed RAM host controller.
// Assumes: 25 MHz clock, 40 ns period.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package nvram_host_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 9;
  localparam int DATA_W     = 8;
  localparam int WORDS      = 512;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS            = 40;
  localparam int CYCLE_TIME_NS     = 300;
  localparam int WRITE_PULSE_NS    = 100;
  localparam int ADDR_SETUP_NS     = 50;
  localparam int SEL_STORE_SETUP_NS = 25;
  localparam int SEL_STORE_END_NS  = 125;
  localparam int STORE_PULSE_NS    = 100;
  localparam int STORE_RESET_NS    = 300;
  localparam int SECOND_GAP_MS     = 5;
  localparam int STORE_CYCLE_MS    = 10;
  localparam int RECALL_PULSE_NS   = 750;
  localparam int RECALL_CYCLE_NS   = 1500;

  function automatic int ceil_cyc(input int ns);
    ceil_cyc = (ns + CLK_NS - 1) / CLK_NS;
    if (ceil_cyc < 1) begin
      ceil_cyc = 1;
    end
  endfunction : ceil_cyc

  localparam int CYC_CYCLE     = ceil_cyc(CYCLE_TIME_NS);
  localparam int CYC_SETUP     = ceil_cyc(ADDR_SETUP_NS);
  localparam int CYC_WPULSE    = ceil_cyc(WRITE_PULSE_NS);
  localparam int CYC_SSETUP    = ceil_cyc(SEL_STORE_SETUP_NS);
  localparam int CYC_SPULSE    = ceil_cyc(STORE_PULSE_NS > SEL_STORE_END_NS ? STORE_PULSE_NS : SEL_STORE_END_NS);
  localparam int CYC_SRESET    = ceil_cyc(STORE_RESET_NS);
  localparam int CYC_GAP       = ceil_cyc(SECOND_GAP_MS * 1000000);
  localparam int CYC_STORE     = ceil_cyc(STORE_CYCLE_MS * 1000000);
  localparam int CYC_RPULSE    = ceil_cyc(RECALL_PULSE_NS);
  localparam int CYC_RCYCLE    = ceil_cyc(RECALL_CYCLE_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_STORE,
    OP_RECALL
  } op_t;

  typedef struct packed {
    op_t                 op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } req_t;

  typedef struct packed {
    logic                device_select_n;
    logic                write_strobe_n;
    logic                store_strobe_n;
    logic                recall_strobe_n;
  } strobes_t;

endpackage : nvram_host_pkg

/* File: rtl/nvram_pin_sync.sv */
// Purpose: Three-stage synchroniser for the data bus read back from the pins.
// Assumes: A change counts once the second and third stages agree.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
module nvram_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire  [W-1:0] agree = ~(s2 ^ s3);
  wire  [W-1:0] next_q = (agree & s3) | (~agree & q_o);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      q_o <= '0;
    end else begin
      s1  <= d_i;
      s2  <= s1;
      s3  <= s2;
      q_o <= next_q;
    end
  end

endmodule : nvram_pin_sync

/* File: bench/nvram_host_chk.sv */
// Purpose: Pin checks for the shadowed RAM host.
// Assumes: One clock; reset_n_i async low.
// Notes:   Store gap is counted in cycles.
`timescale 1ns/1ps
module nvram_host_chk #(
  parameter int GAP_CYCLES = 20
) (
  input  wire logic                                clk_i,
  input  wire logic                                reset_n_i,
  input  wire logic                                req_ready_o,
  input  wire logic                                busy_o,
  input  wire nvram_host_pkg::strobes_t            strobes_o,
  input  wire logic [nvram_host_pkg::ADDR_W-1:0]   word_address_lines_o,
  input  wire logic                                byte_lanes_oe_o
);
  logic        sel;
  logic        w;
  logic        s;
  logic        r;
  logic        seen;
  logic [31:0] gap;
  logic [31:0] span;
  assign sel = !strobes_o.device_select_n;
  assign w   = strobes_o.write_strobe_n;
  assign s   = strobes_o.store_strobe_n;
  assign r   = strobes_o.recall_strobe_n;
  // The first pulse must not be judged against the gap.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap  <= '0;
      span <= '0;
      seen <= 1'b0;
    end else begin
      gap  <= s ? gap + 32'h1 : '0;
      span <= sel ? span + 32'h1 : '0;
      seen <= sel && (seen || !s);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rw;     !w |-> sel && s && r && byte_lanes_oe_o; endproperty
  property p_addr;   sel && $past(sel) |-> $stable(word_address_lines_o); endproperty
  property p_ovl;    s || r; endproperty
  property p_st_sel; !s |-> sel && w && r; endproperty
  property p_lead;   $fell(s) |-> !$past(strobes_o.device_select_n); endproperty
  property p_gap;    $fell(s) && seen |-> gap >= GAP_CYCLES; endproperty
  property p_pulse;  $fell(s) |=> !s [*3]; endproperty
  property p_busy;   !s || !r || !w |-> busy_o; endproperty
  property p_ready;  req_ready_o |-> !busy_o && strobes_o == 4'hf; endproperty
  property p_cycle;  $rose(strobes_o.device_select_n) |-> span >= nvram_host_pkg::CYC_CYCLE; endproperty
  a_rw:     assert property (p_rw) else $error("write strobe outside a write");
  a_addr:   assert property (p_addr) else $error("address moved in cycle");
  a_ovl:    assert property (p_ovl) else $error("store and recall overlap");
  a_st_sel: assert property (p_st_sel) else $error("store pulse unqualified");
  a_lead:   assert property (p_lead) else $error("select late for store");
  a_gap:    assert property (p_gap) else $error("second store pulse early");
  a_pulse:  assert property (p_pulse) else $error("store pulse short");
  a_busy:   assert property (p_busy) else $error("strobe low while idle");
  a_ready:  assert property (p_ready) else $error("ready while active");
  a_cycle:  assert property (p_cycle) else $error("select cycle too short");
  c_wr:  cover property (!w);
  c_rc:  cover property (!r);
  c_gap: cover property ($fell(s) && seen);
endmodule : nvram_host_chk

bind nvram_host nvram_host_chk #(.GAP_CYCLES(GAP_CYCLES)) u_chk (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .req_ready_o(req_ready_o),
  .busy_o(busy_o),
  .strobes_o(strobes_o),
  .word_address_lines_o(word_address_lines_o),
  .byte_lanes_oe_o(byte_lanes_oe_o)
);

/* File: bench/nvram_dev_model.sv */
// Purpose: Behavioural shadowed RAM on the far side.
// Assumes: Sampled on the host clock.
// Notes:   Lanes hold two cycles after a read, then float.
`timescale 1ns/1ps
module nvram_dev_model #(
  parameter int STC = 30
) (
  input  wire logic                     clk_i,
  input  wire nvram_host_pkg::strobes_t pin_i,
  input  wire logic [8:0]               addr_i,
  input  wire logic [7:0]               d_i,
  output logic      [7:0]               q_o,
  output logic                          oe_o
);
  logic [7:0]  ram [512];
  logic [7:0]  nv  [512];
  logic [31:0] cnt;
  logic [1:0]  hold;
  logic        pulses;
  logic        prev_st;
  logic        sel;
  logic        rd;
  assign sel  = !pin_i.device_select_n;
  assign rd   = sel && (pin_i == 4'h7) && cnt == 0;
  assign oe_o = hold != 2'd0;
  initial begin
    cnt     = 0;
    hold    = 0;
    pulses  = 0;
    prev_st = 1;
    for (int i = 0; i < 512; i++) begin
      ram[i] = 8'h00;
      nv[i]  = i[7:0] ^ 8'h96;
    end
  end
  always @(posedge clk_i) begin
    prev_st <= pin_i.store_strobe_n;
    q_o     <= ram[addr_i];
    hold    <= rd ? 2'd2 : hold - {1'b0, hold != 2'd0};
    // run down; the last count holds at 1 while store low
    if (cnt != 0) begin
      if (cnt > 1 || pin_i.store_strobe_n) cnt <= cnt - 1;
    end else if (sel && prev_st && !pin_i.store_strobe_n) begin
      pulses <= !pulses;
      if (pulses) begin
        cnt <= STC;
        for (int i = 0; i < 512; i++) nv[i] <= ram[i];
      end
    end else if (!sel) begin
      pulses <= 0;
    end else if (!pin_i.write_strobe_n) begin
      ram[addr_i] <= d_i;
    end else if (!pin_i.recall_strobe_n) begin
      for (int i = 0; i < 512; i++) ram[i] <= nv[i];
    end
  end
endmodule : nvram_dev_model

/* File: bench/shadowed_nv_static_ram_tb_top.sv */
// Purpose: Self-checking bench for the RAM host.
// Assumes: Short gap and store counts.
// Notes:   Lanes resolve from both enables.
`timescale 1ns/1ps
module shadowed_nv_static_ram_tb_top;
  logic                     clk_i;
  logic                     reset_n_i;
  logic                     req_valid;
  nvram_host_pkg::req_t     req;
  logic                     ready;
  logic                     rsp_v;
  logic [7:0]               rsp_d;
  logic                     busy;
  nvram_host_pkg::strobes_t pins;
  logic [8:0]               addr;
  logic [7:0]               wd;
  logic                     oe;
  logic [7:0]               lanes;
  logic [7:0]               last;
  logic [7:0]               m_q;
  logic                     m_oe;
  logic [7:0]               q;
  int                       mismatches;
  int                       num_checks;
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  nvram_host #(.GAP_CYCLES(20), .STORE_CYCLES(40)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(ready), .rsp_valid_o(rsp_v), .rsp_data_o(rsp_d), .busy_o(busy),
    .strobes_o(pins), .word_address_lines_o(addr), .byte_lanes_o(wd),
    .byte_lanes_oe_o(oe), .byte_lanes_i(lanes));
  nvram_dev_model #(.STC(30)) dev (
    .clk_i(clk_i), .pin_i(pins), .addr_i(addr), .d_i(wd), .q_o(m_q), .oe_o(m_oe));
  assign lanes = oe ? wd : (m_oe ? m_q : ~last);
  always @(posedge clk_i) last <= lanes;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic op(input nvram_host_pkg::op_t o, input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1) @(posedge clk_i);
    req_valid <= 1'b1;
    req       <= '{o, a, d};
    @(posedge clk_i);
    req_valid <= 1'b0;
    while (rsp_v !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk(n < 2000, 1);
    q = rsp_d;
  endtask : op
  task automatic t_ram();
    for (int i = 0; i < 3; i++) op(nvram_host_pkg::OP_WRITE, 9'(i * 255), 8'hc3 ^ 8'(i));
    for (int i = 0; i < 3; i++) begin
      op(nvram_host_pkg::OP_READ, 9'(i * 255), 8'h00);
      chk(q, 8'hc3 ^ 8'(i));
    end
  endtask : t_ram
  task automatic t_nv();
    op(nvram_host_pkg::OP_STORE, 9'h000, 8'h00);
    chk(dev.nv[9'h1fe], 8'hc1);
    chk(dev.nv[9'h001], 8'h00);
    op(nvram_host_pkg::OP_WRITE, 9'h0ff, 8'h77);
    op(nvram_host_pkg::OP_RECALL, 9'h000, 8'h00);
    chk(dev.nv[9'h0ff], 8'hc2);
    op(nvram_host_pkg::OP_READ, 9'h0ff, 8'h00);
    chk(q, 8'hc2);
  endtask : t_nv
  task automatic t_reset();
    req_valid <= 1'b1;
    req       <= '{nvram_host_pkg::OP_WRITE, 9'h010, 8'h11};
    @(posedge clk_i);
    req_valid <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b0;
    @(posedge clk_i);
    chk({pins, oe}, 5'h1e);
    reset_n_i <= 1'b1;
    op(nvram_host_pkg::OP_READ, 9'h000, 8'h00);
    chk(q, 8'hc3);
  endtask : t_reset
  initial begin
    mismatches = 0;
    num_checks = 0;
    reset_n_i  = 0;
    req_valid  = 0;
    req        = '0;
    last       = 8'h00;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_ram();
    t_nv();
    t_reset();
    test_done();
  end
  initial begin
    #2000000;
    mismatches++;
    test_done();
  end
endmodule : shadowed_nv_static_ram_tb_top
